// ===== nvm_ctrl.v
// Purpose: data EEPROM access controller behind four special function registers
// Assumes: core strobes are one cycle wide and synchronous to clk
// Notes: array is flip-flops; contents survive rst_n
`timescale 1ns/1ns
`default_nettype none
`include "nvm_ctrl_map.vh"

module nvm_ctrl #(
  parameter ADDR_W       = 8,
  parameter CNT_W        = 16,
  parameter WRITE_CYCLES = `NVM_WRITE_CYCLES,
  parameter PUT_W        = 22,
  parameter PUT_CYCLES   = `NVM_PUT_MS * `NVM_CLK_KHZ
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // Special function register access
  input  wire [11:0] sfr_addr,
  input  wire        sfr_wr_en,
  input  wire        sfr_rd_en,
  input  wire [7:0]  sfr_wdata,
  output reg  [7:0]  sfr_rdata,
  // Write-done flag
  input  wire        write_done_clr,
  output wire        write_done_flag,
  // Status
  output wire        write_busy,
  output wire        writes_blocked
);

  localparam DEPTH = 1 << ADDR_W;

  localparam [31:0] WR_LOAD_FULL  = WRITE_CYCLES - 1;
  localparam [31:0] PUT_LOAD_FULL = PUT_CYCLES - 1;

  // Cut to counter width on purpose; the widths must hold the counts
  localparam [CNT_W-1:0] WR_LOAD  = WR_LOAD_FULL[CNT_W-1:0];
  localparam [PUT_W-1:0] PUT_LOAD = PUT_LOAD_FULL[PUT_W-1:0];
  localparam [CNT_W-1:0] CNT_ZERO = {CNT_W{1'b0}};
  localparam [PUT_W-1:0] PUT_ZERO = {PUT_W{1'b0}};

  reg [7:0]       mem [0:DEPTH-1];
  reg [7:0]       nvm_address_reg;
  reg [7:0]       nvm_data_reg;
  reg             program_space_select_reg;
  reg             config_space_select_reg;
  reg             row_erase_reg;
  reg             write_abort_flag_reg;
  reg             write_permit_reg;
  reg             write_trigger_reg;
  reg             read_trigger_reg;
  reg             write_done_flag_reg;
  reg [1:0]       unlock_state_reg;
  reg [1:0]       unlock_state_next;
  reg [CNT_W-1:0] write_cnt_reg;
  reg [PUT_W-1:0] put_cnt_reg;
  reg             put_active_reg;

  wire            any_access;
  wire            wr_control;
  wire            wr_unlock;
  wire            wr_data;
  wire            wr_address;
  wire            wr_request;
  wire            write_go;
  wire            write_bad;
  wire            read_go;
  wire            write_finish;
  wire [ADDR_W-1:0] mem_index;
  wire [7:0]      control_image;

  assign any_access = sfr_wr_en | sfr_rd_en;
  assign wr_control = sfr_wr_en && (sfr_addr == `NVM_CONTROL_ADDR);
  assign wr_unlock  = sfr_wr_en && (sfr_addr == `NVM_UNLOCK_ADDR);
  assign wr_data    = sfr_wr_en && (sfr_addr == `NVM_DATA_ADDR);
  assign wr_address = sfr_wr_en && (sfr_addr == `NVM_ADDRESS_ADDR);
  assign mem_index  = nvm_address_reg[ADDR_W-1:0];

  assign wr_request = wr_control && sfr_wdata[`NVM_BIT_WR] && !write_trigger_reg;

  // Permit is the stored bit, so a write setting both cannot start
  assign write_go = wr_request &&
                    (unlock_state_reg == `NVM_UNL_ARM) &&
                    write_permit_reg &&
                    !put_active_reg &&
                    !program_space_select_reg &&
                    !config_space_select_reg;

  assign write_bad = wr_request && !write_go;

  assign read_go = wr_control && sfr_wdata[`NVM_BIT_RD] && !write_trigger_reg &&
                   !program_space_select_reg && !config_space_select_reg;

  assign write_finish = write_trigger_reg && (write_cnt_reg == CNT_ZERO);

  assign write_busy      = write_trigger_reg;
  assign writes_blocked  = put_active_reg;
  assign write_done_flag = write_done_flag_reg;

  // Control read image, each field at its mapped position
  assign control_image[`NVM_BIT_PGM]    = program_space_select_reg;
  assign control_image[`NVM_BIT_CFG]    = config_space_select_reg;
  assign control_image[`NVM_BIT_UNUSED] = `NVM_BIT_RESET;
  assign control_image[`NVM_BIT_FREE]   = row_erase_reg;
  assign control_image[`NVM_BIT_ERR]    = write_abort_flag_reg;
  assign control_image[`NVM_BIT_WRITE_PERMIT]   = write_permit_reg;
  assign control_image[`NVM_BIT_WR]     = write_trigger_reg;
  assign control_image[`NVM_BIT_RD]     = read_trigger_reg;

  // Unlock detector
  always @* begin
    unlock_state_next = unlock_state_reg;
    case (unlock_state_reg)
      `NVM_UNL_IDLE: begin
        if (wr_unlock && sfr_wdata == `NVM_KEY_FIRST)
          unlock_state_next = `NVM_UNL_HALF;
      end
      `NVM_UNL_HALF: begin
        if (wr_unlock && sfr_wdata == `NVM_KEY_SECOND)
          unlock_state_next = `NVM_UNL_ARM;
        else if (wr_unlock && sfr_wdata == `NVM_KEY_FIRST)
          unlock_state_next = `NVM_UNL_HALF;
        else if (any_access)
          unlock_state_next = `NVM_UNL_IDLE;
      end
      `NVM_UNL_ARM: begin
        // Armed for one access only, whatever it is
        if (any_access)
          unlock_state_next = `NVM_UNL_IDLE;
      end
      default: begin
        unlock_state_next = `NVM_UNL_IDLE;
      end
    endcase
    if (write_trigger_reg)
      unlock_state_next = `NVM_UNL_IDLE;
  end

  always @(posedge clk) begin
    if (!rst_n)
      unlock_state_reg <= `NVM_UNL_IDLE;
    else
      unlock_state_reg <= unlock_state_next;
  end

  // Power-up timer, restarted by every reset
  always @(posedge clk) begin
    if (!rst_n) begin
      put_cnt_reg    <= PUT_LOAD;
      put_active_reg <= `NVM_BIT_SET;
    end else if (put_active_reg) begin
      if (put_cnt_reg == PUT_ZERO)
        put_active_reg <= 1'b0;
      else
        put_cnt_reg <= put_cnt_reg - 1'b1;
    end
  end

  // Self-timed write counter
  always @(posedge clk) begin
    if (!rst_n)
      write_cnt_reg <= CNT_ZERO;
    else if (write_go)
      write_cnt_reg <= WR_LOAD;
    else if (write_trigger_reg && write_cnt_reg != CNT_ZERO)
      write_cnt_reg <= write_cnt_reg - 1'b1;
  end

  // Control register
  always @(posedge clk) begin
    if (!rst_n) begin
      // Selects kept if a write is cut short, for diagnosis
      if (!write_trigger_reg) begin
        program_space_select_reg <= `NVM_BIT_RESET;
        config_space_select_reg  <= `NVM_BIT_RESET;
      end
      write_abort_flag_reg <= write_trigger_reg;
      row_erase_reg        <= `NVM_BIT_RESET;
      write_permit_reg     <= `NVM_BIT_RESET;
      write_trigger_reg    <= `NVM_BIT_RESET;
      read_trigger_reg     <= `NVM_BIT_RESET;
    end else begin
      read_trigger_reg <= read_go;
      if (wr_control && !write_trigger_reg) begin
        program_space_select_reg <= sfr_wdata[`NVM_BIT_PGM];
        config_space_select_reg  <= sfr_wdata[`NVM_BIT_CFG];
        row_erase_reg            <= sfr_wdata[`NVM_BIT_FREE];
        write_permit_reg         <= sfr_wdata[`NVM_BIT_WRITE_PERMIT];
      end
      // Hardware set wins over a software clear
      if (write_bad)
        write_abort_flag_reg <= 1'b1;
      else if (wr_control && !write_trigger_reg)
        write_abort_flag_reg <= sfr_wdata[`NVM_BIT_ERR];
      // Software sets only; completion here, or reset, clears
      if (write_go)
        write_trigger_reg <= 1'b1;
      else if (write_finish)
        write_trigger_reg <= 1'b0;
    end
  end

  // Address and data registers
  always @(posedge clk) begin
    if (!rst_n) begin
      nvm_address_reg <= `NVM_BYTE_RESET;
      nvm_data_reg    <= `NVM_BYTE_RESET;
    end else if (!write_trigger_reg) begin
      if (wr_address)
        nvm_address_reg <= sfr_wdata;
      if (read_go)
        nvm_data_reg <= mem[mem_index];
      else if (wr_data)
        nvm_data_reg <= sfr_wdata;
    end
  end

  // Array update; reset does not touch stored bytes
  always @(posedge clk) begin
    if (rst_n && write_finish)
      mem[mem_index] <= nvm_data_reg;
  end

  // Write-done flag, set wins over clear
  always @(posedge clk) begin
    if (!rst_n)
      write_done_flag_reg <= `NVM_BIT_RESET;
    else if (write_finish)
      write_done_flag_reg <= 1'b1;
    else if (write_done_clr)
      write_done_flag_reg <= 1'b0;
  end

  // Read-back mux; unlock register reads as zero
  always @* begin
    case (sfr_addr)
      `NVM_CONTROL_ADDR: begin
        sfr_rdata = control_image;
      end
      `NVM_DATA_ADDR: begin
        sfr_rdata = nvm_data_reg;
      end
      `NVM_ADDRESS_ADDR: begin
        sfr_rdata = nvm_address_reg;
      end
      default: begin
        sfr_rdata = `NVM_BYTE_RESET;
      end
    endcase
  end

endmodule // nvm_ctrl

`default_nettype wire

// ===== nvm_ctrl_assertions.sv
// Purpose: port checks for the data EEPROM controller
// Assumes: one clock, synchronous active-low reset
// Notes: bound into nvm_ctrl below
`timescale 1ns/1ns
`default_nettype none
`include "nvm_ctrl_map.vh"
module nvm_ctrl_assertions #(
  parameter WRITE_CYCLES = `NVM_WRITE_CYCLES
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Register access
  input wire logic [11:0] sfr_addr,
  input wire logic        sfr_wr_en,
  input wire logic [7:0]  sfr_wdata,
  input wire logic [7:0]  sfr_rdata,
  // Flag and status
  input wire logic        write_done_clr,
  input wire logic        write_done_flag,
  input wire logic        write_busy,
  input wire logic        writes_blocked
);
  // Counts busy cycles; cleared by reset so an aborted write leaves no residue
  logic [15:0] busy_cnt_reg;
  always @(posedge clk) begin
    busy_cnt_reg <= (!rst_n || !write_busy) ? 16'h0000 : busy_cnt_reg + 16'h0001;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // A reset that cuts a write also drops busy; only completions count
  AST_BUSY_LEN: assert property ($fell(write_busy) && $past(rst_n) |-> busy_cnt_reg == WRITE_CYCLES)
    else $error("write busy length wrong");
  AST_BUSY_MAX: assert property (write_busy |-> busy_cnt_reg < WRITE_CYCLES)
    else $error("write busy too long");
  AST_WR_HOLD: assert property (write_busy && busy_cnt_reg < WRITE_CYCLES - 1 |=> write_busy)
    else $error("write trigger cleared early");
  AST_DONE_SET: assert property ($fell(write_busy) && $past(rst_n) |-> write_done_flag)
    else $error("done flag not set at write end");
  AST_DONE_HOLD: assert property (write_done_flag && !write_done_clr |=> write_done_flag)
    else $error("done flag dropped without clear");
  AST_START_SRC: assert property ($rose(write_busy) |-> $past(sfr_wr_en) &&
    $past(sfr_addr) == `NVM_CONTROL_ADDR && ($past(sfr_wdata) & 8'h06) == 8'h06)
    else $error("write started without control write");
  AST_BLOCKED: assert property (writes_blocked |-> !write_busy)
    else $error("write running while blocked");
  AST_BLOCK_RST: assert property ($rose(rst_n) |-> writes_blocked)
    else $error("power-up block missing");
  AST_RD_CLEAR: assert property (sfr_addr == `NVM_CONTROL_ADDR && sfr_rdata[0] && !sfr_wr_en
    ##1 sfr_addr == `NVM_CONTROL_ADDR |-> !sfr_rdata[0])
    else $error("read trigger not self-cleared");
endmodule // nvm_ctrl_assertions
bind nvm_ctrl nvm_ctrl_assertions #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (.clk(clk), .rst_n(rst_n),
  .sfr_addr(sfr_addr), .sfr_wr_en(sfr_wr_en), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
  .write_done_clr(write_done_clr), .write_done_flag(write_done_flag),
  .write_busy(write_busy), .writes_blocked(writes_blocked));
`default_nettype wire

// ===== nvm_ctrl_map.vh
// Purpose: register map, field positions and timing constants of the data EEPROM controller
// Assumes: 12-bit special function register addresses, 8-bit data
// Notes: included by nvm_ctrl.v, the assertions and the bench
// How it works
// - Read byte valid in next cycle
// - Data register holds read byte until replaced
// - Write needs 55h then AAh unlock first
// - Write trigger refused without write permit set
// - Only software or reset changes write permit
// - Control, address, data frozen during write
// - Permit must be set before the unlock writes
// - Completion clears write trigger, sets done flag
// - Done flag stays set until software or reset clears
// - Read self-clears after one cycle; selects block it
// - Software can set write trigger, never clear
// - Reset during a write or improper attempt sets abort flag
// - Power-up clears permit, blocks writes 72 ms
`ifndef NVM_CTRL_MAP_VH
`define NVM_CTRL_MAP_VH

// Register addresses
`define NVM_CONTROL_ADDR 12'hFA6
`define NVM_UNLOCK_ADDR  12'hFA7
`define NVM_DATA_ADDR    12'hFA8
`define NVM_ADDRESS_ADDR 12'hFA9

// Control register fields
`define NVM_BIT_PGM  7
`define NVM_BIT_CFG  6
`define NVM_BIT_UNUSED 5
`define NVM_BIT_FREE 4
`define NVM_BIT_ERR  3
`define NVM_BIT_WRITE_PERMIT 2
`define NVM_BIT_WR   1
`define NVM_BIT_RD   0

// Unlock keys
`define NVM_KEY_FIRST  8'h55
`define NVM_KEY_SECOND 8'hAA

// Reset values
`define NVM_BYTE_RESET 8'h00
`define NVM_BIT_RESET  1'b0
`define NVM_BIT_SET    1'b1

// Unlock detector states
`define NVM_UNL_IDLE 2'h0
`define NVM_UNL_HALF 2'h1
`define NVM_UNL_ARM  2'h2

// Timing
`define NVM_CLK_KHZ      50000
`define NVM_PUT_MS       72
`define NVM_WRITE_CYCLES 200

`endif

// ===== nvm_ctrl_tb.sv
// Purpose: self-checking bench for the data EEPROM controller
// Assumes: short write and power-up counts
// Notes: expected array kept here
`timescale 1ns/1ns
`default_nettype none
`include "nvm_ctrl_map.vh"
module nvm_ctrl_tb;
  localparam [11:0] CT = `NVM_CONTROL_ADDR;
  localparam [11:0] UL = `NVM_UNLOCK_ADDR;
  localparam [11:0] DT = `NVM_DATA_ADDR;
  localparam [11:0] AD = `NVM_ADDRESS_ADDR;
  logic        clk, rst_n, wr_en, rd_en, done_clr, done, busy, blocked;
  logic [11:0] addr;
  logic [7:0]  wdata, rdata, a, d, v;
  logic [7:0]  mem_exp [0:255];
  logic [31:0] seed;
  integer      err_total, checked, cyc, i, n;
  nvm_ctrl #(.WRITE_CYCLES(8), .PUT_CYCLES(20)) uut (.clk(clk), .rst_n(rst_n),
    .sfr_addr(addr), .sfr_wr_en(wr_en), .sfr_rd_en(rd_en), .sfr_wdata(wdata),
    .sfr_rdata(rdata), .write_done_clr(done_clr), .write_done_flag(done),
    .write_busy(busy), .writes_blocked(blocked));
  function [31:0] xs(input [31:0] s);
    logic [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task print_verdict;
    begin
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task chk(input string nm, input [7:0] e, input [7:0] g);
    begin
      checked = checked + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("wrong value %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task wr(input [11:0] ad, input [7:0] dt);
    begin
      @(posedge clk);
      #1 addr = ad;
      wdata = dt;
      wr_en = 1'b1;
      @(posedge clk);
      #1 wr_en = 1'b0;
    end
  endtask
  task rc(input string nm, input [11:0] ad, input [7:0] e);
    begin
      @(posedge clk);
      #1 addr = ad;
      rd_en = 1'b1;
      #5 chk(nm, e, rdata);
      @(posedge clk);
      #1 rd_en = 1'b0;
    end
  endtask
  // No other access may fall inside these three steps
  task arm;
    begin
      wr(UL, `NVM_KEY_FIRST);
      wr(UL, `NVM_KEY_SECOND);
      wr(CT, 8'h06);
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      err_total = err_total + 1;
      print_verdict;
    end
  end
  initial begin
    {rst_n, wr_en, rd_en, done_clr, addr, wdata} = 0;
    {seed, err_total, checked, cyc} = {32'd70, 96'd0};
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    chk("blocked", 8'h01, {7'h00, blocked});
    rc("control", CT, 8'h00);
    wr(CT, 8'h04);
    arm;
    chk("busy", 8'h00, {7'h00, busy});
    rc("control", CT, 8'h0C);
    while (blocked !== 1'b0) begin
      @(posedge clk);
      #1;
    end
    wr(CT, 8'h00);
    arm;
    chk("busy", 8'h00, {7'h00, busy});
    rc("control", CT, 8'h0C);
    wr(CT, 8'h04);
    wr(CT, 8'h06);
    chk("busy", 8'h00, {7'h00, busy});
    wr(UL, `NVM_KEY_FIRST);
    rc("data", DT, 8'h00);
    wr(UL, `NVM_KEY_SECOND);
    wr(CT, 8'h06);
    chk("busy", 8'h00, {7'h00, busy});
    for (i = 0; i < 4; i = i + 1) begin
      seed = xs(seed);
      a = (i == 0) ? 8'hFF : seed[7:0];
      d = seed[15:8];
      mem_exp[a] = d;
      wr(AD, a);
      wr(DT, d);
      wr(CT, 8'h04);
      arm;
      chk("busy", 8'h01, {7'h00, busy});
      wr(AD, ~a);
      wr(DT, ~d);
      wr(CT, 8'h00);
      // Look a step after each edge so busy has settled
      for (n = 0; n < 50 && busy !== 1'b0; n = n + 1) begin
        @(posedge clk);
        #1;
      end
      chk("done", 8'h01, {7'h00, done});
      rc("address", AD, a);
      rc("data", DT, d);
      rc("control", CT, 8'h04);
      chk("done", 8'h01, {7'h00, done});
      done_clr = 1'b1;
      @(posedge clk);
      #1 done_clr = 1'b0;
      chk("done", 8'h00, {7'h00, done});
    end
    wr(CT, 8'h00);
    seed = 32'd70;
    for (i = 0; i < 4; i = i + 1) begin
      seed = xs(seed);
      a = (i == 0) ? 8'hFF : seed[7:0];
      wr(AD, a);
      wr(CT, 8'h01);
      addr = DT;
      #5 chk("data", mem_exp[a], rdata);
      rc("data", DT, mem_exp[a]);
    end
    wr(CT, 8'h90);
    wr(CT, 8'h91);
    rc("control", CT, 8'h90);
    wr(CT, 8'h40);
    wr(CT, 8'h41);
    rc("control", CT, 8'h40);
    wr(CT, 8'h00);
    wr(CT, 8'h01);
    rc("control", CT, 8'h00);
    wr(CT, 8'h04);
    arm;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b0;
    @(posedge clk);
    #1 rst_n = 1'b1;
    chk("blocked", 8'h01, {7'h00, blocked});
    rc("control", CT, 8'h08);
    print_verdict;
  end
endmodule // nvm_ctrl_tb
`default_nettype wire
